// ==== csda_pkg.sv ====
package csda_pkg;

    // instruction kinds held by the execute stage
    typedef enum logic [1:0] {
        CSDA_OP_NONE,
        CSDA_OP_CMP_LT,
        CSDA_OP_DAA
    } csda_op_type;

    typedef enum logic [1:0] {
        CSDA_ST_IDLE,
        CSDA_ST_EXEC,
        CSDA_ST_FLUSH
    } csda_state_type;

    // instruction encodings
    localparam logic [6:0]  CMP_LT_OPCODE  = 7'h30;
    localparam int          CMP_OPC_MSB    = 15;
    localparam int          CMP_OPC_LSB    = 9;
    localparam int          ACCESS_BIT_POS = 8;
    localparam logic [15:0] DAA_WORD       = 16'h0007;

    // decimal adjust figures
    localparam logic [3:0]  BCD_DIGIT_MAX  = 4'h9;
    localparam logic [3:0]  BCD_FIX        = 4'h6;

    // instruction cycle phases
    localparam logic [1:0]  PH_Q1          = 2'h0;
    localparam logic [1:0]  PH_Q2          = 2'h1;
    localparam logic [1:0]  PH_Q3          = 2'h2;
    localparam logic [1:0]  PH_Q4          = 2'h3;

    // discarded words after a taken skip
    localparam logic [1:0]  FLUSH_ONE      = 2'h1;
    localparam logic [1:0]  FLUSH_TWO      = 2'h2;

    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [1:0]  RST_COUNT      = 2'h0;

endpackage : csda_pkg

// ==== csda_qphase.sv ====
`timescale 1ns/10ps
module csda_qphase
    import csda_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    output logic [1:0]      phase,
    output logic            q1_en,
    output logic            q2_en,
    output logic            q3_en,
    output logic            q4_en
);
    logic [1:0] phase_ff;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_ff <= RST_COUNT;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    assign phase = phase_ff;
    assign q1_en = (phase_ff == PH_Q1);
    assign q2_en = (phase_ff == PH_Q2);
    assign q3_en = (phase_ff == PH_Q3);
    assign q4_en = (phase_ff == PH_Q4);

endmodule : csda_qphase

// ==== csda_core.sv ====
// Summary of operation
// - compare-skip-if-less tests whether the file register is below the accumulator, unsigned.
// - the compare is a subtraction whose result is dropped and no flag is touched.
// - compare-skip-if-less carries an 8-bit file address 0 to 255 and a one-bit bank access bit.
// - when the register is not less, execution simply continues with the next instruction.
// - a taken skip discards the fetched word and spends a full four-phase no-op cycle on it.
// - a taken skip over a two-word instruction makes the compare take three cycles in all.
// - decimal adjust is one word, works only on the accumulator and has no operands.
// - decimal adjust adds 6 to the low nibble when it is above 9 or digit carry is set.
`timescale 1ns/10ps
module csda_core
    import csda_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        next_two_word,
    input  wire logic [7:0]  file_data,
    input  wire logic [7:0]  w_in,
    input  wire logic        carry_in,
    input  wire logic        digit_carry_flag,
    output logic             q1_ff,
    output logic             file_rd_ff,
    output logic [7:0]       file_addr_ff,
    output logic             bank_access_ff,
    output logic             skip_ff,
    output logic             nop_cycle_ff,
    output logic             w_wr_ff,
    output logic [7:0]       w_res_ff,
    output logic             carry_wr_ff,
    output logic             carry_res_ff
);
    function automatic logic is_cmp_lt(input logic [15:0] word);
        is_cmp_lt = (word[CMP_OPC_MSB:CMP_OPC_LSB] == CMP_LT_OPCODE);
    endfunction : is_cmp_lt

    // returns {carry, adjusted byte}
    function automatic logic [8:0] daa_calc(input logic [7:0] w,
                                            input logic       c,
                                            input logic       dc);
        logic [8:0] lo_sum;
        logic       hi_fix;
        lo_sum = {1'b0, w};
        if ((w[3:0] > BCD_DIGIT_MAX) || dc) begin
            lo_sum = lo_sum + {5'h00, BCD_FIX};
        end
        hi_fix = (lo_sum[7:4] > BCD_DIGIT_MAX) || c || lo_sum[8];
        if (hi_fix) begin
            daa_calc = {1'b1, lo_sum[7:4] + BCD_FIX, lo_sum[3:0]};
        end else begin
            daa_calc = {c, lo_sum[7:0]};
        end
    endfunction : daa_calc

    logic [1:0]     phase;
    logic           q1_en;
    logic           q2_en;
    logic           q3_en;
    logic           q4_en;
    csda_state_type state_ff;
    csda_op_type    op_ff;
    logic [7:0]     cmp_data_ff;
    logic [1:0]     flush_left_ff;
    logic           reg_less;
    logic [8:0]     daa_res;

    csda_qphase u_qphase (
        .sys_clk (sys_clk),
        .srst    (srst),
        .phase   (phase),
        .q1_en   (q1_en),
        .q2_en   (q2_en),
        .q3_en   (q3_en),
        .q4_en   (q4_en)
    );

    // unsigned: register is below the accumulator
    assign reg_less = (cmp_data_ff < w_in);
    assign daa_res  = daa_calc(w_in, carry_in, digit_carry_flag);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q1_ff <= 1'b0;
        end else begin
            q1_ff <= (phase == PH_Q4);
        end
    end

    // decode at Q1; other words belong to other execute units
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff       <= CSDA_ST_IDLE;
            op_ff          <= CSDA_OP_NONE;
            file_addr_ff   <= RST_BYTE;
            bank_access_ff <= 1'b0;
        end else begin
            case (state_ff)
                CSDA_ST_IDLE: begin
                    if (q1_en && instr_valid && is_cmp_lt(instr_word)) begin
                        state_ff       <= CSDA_ST_EXEC;
                        op_ff          <= CSDA_OP_CMP_LT;
                        file_addr_ff   <= instr_word[7:0];
                        bank_access_ff <= instr_word[ACCESS_BIT_POS];
                    end else if (q1_en && instr_valid && instr_word == DAA_WORD) begin
                        state_ff <= CSDA_ST_EXEC;
                        op_ff    <= CSDA_OP_DAA;
                    end
                end
                CSDA_ST_EXEC: begin
                    if (q4_en) begin
                        op_ff <= CSDA_OP_NONE;
                        if (skip_ff) begin
                            state_ff <= CSDA_ST_FLUSH;
                        end else begin
                            state_ff <= CSDA_ST_IDLE;
                        end
                    end
                end
                CSDA_ST_FLUSH: begin
                    if (q4_en && flush_left_ff == FLUSH_ONE) begin
                        state_ff <= CSDA_ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= CSDA_ST_IDLE;
                end
            endcase
        end
    end

    // Q2 read strobe and data capture
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            file_rd_ff  <= 1'b0;
            cmp_data_ff <= RST_BYTE;
        end else begin
            file_rd_ff <= q1_en && state_ff == CSDA_ST_IDLE && instr_valid
                          && is_cmp_lt(instr_word);
            if (file_rd_ff) begin
                cmp_data_ff <= file_data;
            end
        end
    end

    // skip decided in Q3, visible through Q4; no flag write on compare
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            skip_ff <= 1'b0;
        end else begin
            skip_ff <= q3_en && state_ff == CSDA_ST_EXEC && op_ff == CSDA_OP_CMP_LT
                       && reg_less;
        end
    end

    // a two-word successor costs a second dead cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flush_left_ff <= RST_COUNT;
            nop_cycle_ff  <= 1'b0;
        end else if (q4_en && skip_ff) begin
            flush_left_ff <= next_two_word ? FLUSH_TWO : FLUSH_ONE;
            nop_cycle_ff  <= 1'b1;
        end else if (q4_en && state_ff == CSDA_ST_FLUSH) begin
            flush_left_ff <= flush_left_ff - 2'h1;
            nop_cycle_ff  <= (flush_left_ff != FLUSH_ONE);
        end
    end

    // write W and carry in Q4; digit carry is left alone
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            w_wr_ff      <= 1'b0;
            w_res_ff     <= RST_BYTE;
            carry_wr_ff  <= 1'b0;
            carry_res_ff <= 1'b0;
        end else begin
            w_wr_ff     <= q3_en && state_ff == CSDA_ST_EXEC && op_ff == CSDA_OP_DAA;
            carry_wr_ff <= q3_en && state_ff == CSDA_ST_EXEC && op_ff == CSDA_OP_DAA;
            if (q3_en && op_ff == CSDA_OP_DAA) begin
                w_res_ff     <= daa_res[7:0];
                carry_res_ff <= daa_res[8];
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence seq_skip_issued;
        skip_ff && q4_en;
    endsequence

    sequence seq_dead_cycle;
        nop_cycle_ff [*4];
    endsequence

    chk_cmp_no_write: assert property (op_ff == CSDA_OP_CMP_LT |-> !w_wr_ff && !carry_wr_ff)
        else $error("compare wrote a result or flag");
    chk_read_address: assert property ($rose(file_rd_ff) |-> q2_en && file_addr_ff == $past(instr_word[7:0])
        && bank_access_ff == $past(instr_word[ACCESS_BIT_POS]))
        else $error("file address or access bit not taken from the word");
    chk_skip_when_less: assert property (q3_en && op_ff == CSDA_OP_CMP_LT && state_ff == CSDA_ST_EXEC
        |=> skip_ff == ($past(cmp_data_ff) < $past(w_in)))
        else $error("skip decision does not match unsigned compare");
    chk_no_skip_go_on: assert property (q4_en && op_ff == CSDA_OP_CMP_LT && !skip_ff
        |=> state_ff == CSDA_ST_IDLE && !nop_cycle_ff)
        else $error("compare without skip did not continue");
    chk_skip_dead_cycle: assert property (seq_skip_issued |=> seq_dead_cycle)
        else $error("skip did not spend a full no-op cycle");
    chk_skip_two_words: assert property (seq_skip_issued ##0 next_two_word
        |=> seq_dead_cycle ##1 seq_dead_cycle ##1 !nop_cycle_ff)
        else $error("skip over two-word instruction not two dead cycles");
    chk_daa_only_w: assert property (w_wr_ff |-> !file_rd_ff && !skip_ff && $past(op_ff) == CSDA_OP_DAA)
        else $error("accumulator written outside decimal adjust");
    chk_daa_low_nibble: assert property ($rose(w_wr_ff) |-> w_res_ff[3:0] ==
        ((($past(w_in[3:0]) > BCD_DIGIT_MAX) || $past(digit_carry_flag))
        ? $past(w_in[3:0]) + BCD_FIX : $past(w_in[3:0])))
        else $error("low nibble adjust wrong");
    chk_daa_carry_kept: assert property ($rose(carry_wr_ff) && $past(carry_in) |-> carry_res_ff)
        else $error("carry cleared by decimal adjust");
    chk_daa_decode: assert property (q1_en && instr_valid && state_ff == CSDA_ST_IDLE
        && instr_word == DAA_WORD |=> op_ff == CSDA_OP_DAA ##2 w_wr_ff)
        else $error("decimal adjust word not executed");

endmodule : csda_core

// ==== compare_skip_decimal_adjust_tb_top.sv ====
`timescale 1ns/10ps
module compare_skip_decimal_adjust_tb_top;
    import csda_pkg::*;

    logic        sys_clk;
    logic        srst;
    logic        instr_valid;
    logic [15:0] instr_word;
    logic        next_two_word;
    logic [7:0]  file_data;
    logic [7:0]  w_in;
    logic        carry_in;
    logic        digit_carry_flag;
    logic        q1_ff, file_rd_ff, bank_access_ff, skip_ff, nop_cycle_ff;
    logic        w_wr_ff, carry_wr_ff, carry_res_ff;
    logic [7:0]  file_addr_ff, w_res_ff;
    logic [1:0]  tb_phase_ff;
    logic [7:0]  rd_addr, res;
    logic        rd_bank, cres;
    int          fail_count, samples_checked, cyc, total;
    int          rd_cnt, rd_at, skip_cnt, skip_at, nop_cnt, wwr_cnt, cwr_cnt;
    int          q1_bad;

    csda_core DUT (.sys_clk(sys_clk), .srst(srst), .instr_valid(instr_valid),
        .instr_word(instr_word), .next_two_word(next_two_word), .file_data(file_data),
        .w_in(w_in), .carry_in(carry_in), .digit_carry_flag(digit_carry_flag),
        .q1_ff(q1_ff), .file_rd_ff(file_rd_ff), .file_addr_ff(file_addr_ff),
        .bank_access_ff(bank_access_ff), .skip_ff(skip_ff), .nop_cycle_ff(nop_cycle_ff),
        .w_wr_ff(w_wr_ff), .w_res_ff(w_res_ff), .carry_wr_ff(carry_wr_ff),
        .carry_res_ff(carry_res_ff));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // mirror of the free-running phase: zero here means the next edge is a Q1 edge
    always @(posedge sys_clk) begin
        tb_phase_ff <= srst ? 2'h0 : tb_phase_ff + 2'h1;
        total = total + 1;
        if (total > 3000) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0t timeout", $time);
            final_report();
        end
    end

    // outputs gathered at the falling edge, where they are settled
    always @(negedge sys_clk) begin
        cyc = cyc + 1;
        if (file_rd_ff === 1'b1) begin
            rd_cnt = rd_cnt + 1;
            rd_at = cyc;
            rd_addr = file_addr_ff;
            rd_bank = bank_access_ff;
        end
        if (skip_ff === 1'b1) begin
            skip_cnt = skip_cnt + 1;
            skip_at = cyc;
        end
        if (nop_cycle_ff === 1'b1) nop_cnt = nop_cnt + 1;
        // phase marker must stand exactly in the Q1 clock once reset is behind us
        if (srst === 1'b0 && cyc > 7 && q1_ff !== (tb_phase_ff == 2'h0)) q1_bad = q1_bad + 1;
        if (carry_wr_ff === 1'b1) cwr_cnt = cwr_cnt + 1;
        if (w_wr_ff === 1'b1) begin
            wwr_cnt = wwr_cnt + 1;
            res = w_res_ff;
            cres = carry_res_ff;
        end
    end

    task automatic chk(input logic ok, input string msg);
        samples_checked = samples_checked + 1;
        if (ok !== 1'b1) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk

    task automatic clr();
        @(posedge sys_clk);
        {rd_cnt, skip_cnt, nop_cnt, wwr_cnt, cwr_cnt, rd_at, skip_at, q1_bad} = '0;
    endtask : clr

    task automatic issue(input logic [15:0] word);
        @(negedge sys_clk);
        while (tb_phase_ff !== 2'h0) @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = word;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        instr_word = 16'h0000;
    endtask : issue

    task automatic run_cmp(input logic [7:0] f, w, addr, input logic a, two);
        logic sk;
        sk = (f < w);
        clr();
        file_data = f;
        w_in = w;
        next_two_word = two;
        issue({CMP_LT_OPCODE, a, addr});
        repeat (16) @(negedge sys_clk);
        chk(rd_cnt == 1 && rd_addr === addr && rd_bank === a, "compare operands");
        chk(skip_cnt == (sk ? 1 : 0), "skip decision");
        chk(!sk || skip_at == rd_at + 2, "skip moment");
        chk(nop_cnt == (sk ? (two ? 8 : 4) : 0), "discard length");
        chk(wwr_cnt == 0 && cwr_cnt == 0, "compare wrote a result");
        chk(q1_bad == 0, "phase marker out of step");
    endtask : run_cmp

    task automatic run_daa(input logic [7:0] w, input logic c, dc, input logic [7:0] ew,
                           input logic ec);
        clr();
        w_in = w;
        carry_in = c;
        digit_carry_flag = dc;
        issue(DAA_WORD);
        repeat (16) @(negedge sys_clk);
        chk(wwr_cnt == 1 && cwr_cnt == 1 && res === ew, "adjust value");
        chk(cres === ec, "adjust carry");
        chk(rd_cnt == 0 && skip_cnt == 0, "adjust touched file");
    endtask : run_daa

    // word offered during the flush must be swallowed
    task automatic run_flush_refuse();
        clr();
        file_data = 8'h10;
        w_in = 8'h20;
        next_two_word = 1'b0;
        issue({CMP_LT_OPCODE, 1'b0, 8'h44});
        issue(DAA_WORD);
        repeat (16) @(negedge sys_clk);
        chk(skip_cnt == 1 && wwr_cnt == 0, "discarded word executed");
    endtask : run_flush_refuse

    // no skip: the very next word runs at once
    task automatic run_back_to_back();
        clr();
        file_data = 8'ha0;
        w_in = 8'h99;
        {carry_in, digit_carry_flag} = 2'b00;
        issue({CMP_LT_OPCODE, 1'b1, 8'h07});
        issue(DAA_WORD);
        repeat (16) @(negedge sys_clk);
        chk(skip_cnt == 0 && nop_cnt == 0 && wwr_cnt == 1 && res === 8'h99, "next word lost");
    endtask : run_back_to_back

    task automatic run_foreign_words();
        clr();
        issue(16'h6512);
        issue(16'h0008);
        issue(16'h6112);
        repeat (16) @(negedge sys_clk);
        chk(rd_cnt == 1 && wwr_cnt == 0, "foreign word decoded");
    endtask : run_foreign_words

    task automatic final_report();
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    initial begin
        {fail_count, samples_checked, cyc, total} = '0;
        srst = 1'b1;
        {instr_valid, next_two_word, carry_in, digit_carry_flag} = 4'h0;
        {instr_word, file_data, w_in} = '0;
        repeat (6) @(negedge sys_clk);
        chk({file_rd_ff, skip_ff, nop_cycle_ff, w_wr_ff, carry_wr_ff} === 5'h00, "reset");
        srst = 1'b0;
        run_cmp(8'h10, 8'h11, 8'h00, 1'b0, 1'b0);
        run_cmp(8'h80, 8'h80, 8'hff, 1'b1, 1'b0);
        run_cmp(8'hff, 8'h00, 8'h5a, 1'b0, 1'b1);
        run_cmp(8'h7f, 8'h80, 8'ha5, 1'b1, 1'b1);
        run_cmp(8'h00, 8'hff, 8'h01, 1'b0, 1'b1);
        run_daa(8'ha5, 1'b0, 1'b0, 8'h05, 1'b1);
        run_daa(8'hce, 1'b0, 1'b0, 8'h34, 1'b1);
        run_daa(8'h12, 1'b1, 1'b0, 8'h72, 1'b1);
        run_daa(8'h11, 1'b0, 1'b1, 8'h17, 1'b0);
        run_daa(8'h99, 1'b0, 1'b0, 8'h99, 1'b0);
        run_flush_refuse();
        run_back_to_back();
        run_foreign_words();
        final_report();
    end
endmodule : compare_skip_decimal_adjust_tb_top
